// [hw/smd_top.sv]
// Purpose: sector map discovery table and map selection, reached over APB
// Assumes: single 40 MHz clock pclk, asynchronous active-low presetn
// Notes:   table words are fetched byte by byte and assembled before pready
//
// Notes on behaviour
// [RULE_01] map index is architecture bit, parameter location bit, uniform size bit, msb first
// [RULE_02] architecture bit 0 selects hybrid map, 1 selects uniform map
// [RULE_03] parameter location bit 0 puts small sectors at bottom, 1 at top
// [RULE_04] uniform size bit 1 means 256-kB sectors, 0 means 64-kB sectors
// [RULE_05] only index values 1, 3 and 5 are defined maps
// [RULE_06] host must not configure any other index combination
// [RULE_07] detection steps use read-any-register 65h, variable address length and latency
// [RULE_08] step one reads config three at 04h with mask 08h, bit 3
// [RULE_09] step two reads config one at 02h with mask 04h, bit 2
// [RULE_10] step three reads config three at 04h with mask 02h, bit 1
// [RULE_11] detection descriptors have type bit 0; only the third has end flag set
// [RULE_12] map header holds region count minus one, config id, descriptor bit 1
// [RULE_13] region size is count of 256-byte units minus one in bits 31:8
// [RULE_14] small-sector region supports only erase type 1
// [RULE_15] reserved bits 7:2 of descriptors and headers read all ones
// [RULE_16] larger-sector regions support only erase type 3
// [RULE_17] words are assembled from four bytes, lowest offset least significant
//
// The implementer's own choices: register access over APB and the register addresses.

`timescale 1ns/10ps
`default_nettype none

module smd_top
  import smd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  output logic      [2:0]  map_index,
  output logic             map_valid,
  output logic             map_hybrid,
  output logic             param_top,
  output logic             uniform_256k
);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DONE} smd_state_t;

  smd_state_t  state_q;
  smd_state_t  next_state;
  logic [2:0]  cnt_q;
  logic [2:0]  next_cnt;
  logic [3:0]  widx_q;
  logic [3:0]  next_widx;
  logic [31:0] prdata_q;
  logic [31:0] next_prdata;
  logic        err_q;
  logic        next_err;
  logic [7:0]  nvcfg1_q;
  logic [7:0]  next_nvcfg1;
  logic [7:0]  nvcfg3_q;
  logic [7:0]  next_nvcfg3;
  logic        unsup_q;
  logic        next_unsup;
  smd_map_t    map_q;
  smd_map_t    next_map;
  smd_sel_t    sel;
  smd_kind_t   kind;
  logic        setup;
  logic        wr_take;
  logic [1:0]  lane;
  logic [5:0]  rom_addr;
  logic [7:0]  rom_byte;
  logic [31:0] status_word;
  logic [11:0] tbl_off;

  assign setup   = psel && !penable;
  assign kind    = smd_decode(paddr);
  assign tbl_off = paddr - OFF_TBL_BASE;
  assign lane    = 2'(cnt_q - 3'h1);
  assign rom_addr = {widx_q, cnt_q[1:0]};

  smd_rom u_rom (
    .pclk      (pclk),
    .presetn   (presetn),
    .byte_addr (rom_addr),
    .byte_data (rom_byte)
  );

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // table reads wait for four bytes; registers answer in the first access cycle
  assign pready  = (state_q == ST_DONE) || (state_q == ST_IDLE && psel && penable);
  assign pslverr = pready && err_q;
  assign prdata  = prdata_q;
  assign wr_take = state_q == ST_IDLE && psel && penable && pwrite && pstrb[0];

  always_comb begin
    status_word            = 32'h0000_0000;
    status_word[ST_IDX_LSB +: 3] = map_q.index;
    status_word[ST_VALID]  = map_q.valid;
    status_word[ST_HYBRID] = map_q.hybrid;
    status_word[ST_PTOP]   = map_q.ptop;
    status_word[ST_U256]   = map_q.u256;
    status_word[ST_UNSUP]  = unsup_q;
  end

  always_comb begin
    next_state  = state_q;
    next_cnt    = cnt_q;
    next_widx   = widx_q;
    next_prdata = prdata_q;
    next_err    = err_q;
    unique case (state_q)
      ST_IDLE: begin
        if (setup) begin
          next_err    = (kind == K_NONE) || (pwrite && kind == K_TBL);
          next_prdata = 32'h0000_0000;
          if (!pwrite) begin
            unique case (kind)
              K_CFG1: next_prdata = {24'h000000, nvcfg1_q};
              K_CFG3: next_prdata = {24'h000000, nvcfg3_q};
              K_STAT: next_prdata = status_word;
              K_TBL: begin
                next_state = ST_FETCH;
                next_cnt   = 3'h0;
                next_widx  = tbl_off[5:2];
              end
              K_NONE: next_prdata = 32'h0000_0000;
            endcase
          end
        end
      end
      ST_FETCH: begin
        next_cnt = cnt_q + 3'h1;
        if (cnt_q != 3'h0) begin
          next_prdata[{lane, 3'h0} +: 8] = rom_byte;  // RULE_17
        end
        if (cnt_q == FETCH_LAST) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (psel && penable) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 3'h0;
      widx_q   <= 4'h0;
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else begin
      state_q  <= next_state;
      cnt_q    <= next_cnt;
      widx_q   <= next_widx;
      prdata_q <= next_prdata;
      err_q    <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // configuration and map selection
  // ----------------------------------------------------------------
  // unsupported combinations are accepted but flagged; a set beats a clear
  always_comb begin
    next_nvcfg1 = nvcfg1_q;
    next_nvcfg3 = nvcfg3_q;
    next_unsup  = unsup_q;
    if (wr_take && kind == K_CFG1) begin
      next_nvcfg1 = pwdata[7:0];
    end
    if (wr_take && kind == K_CFG3) begin
      next_nvcfg3 = pwdata[7:0];
    end
    if (wr_take && kind == K_STAT && pwdata[ST_UNSUP]) begin
      next_unsup = 1'b0;
    end
    if (!map_q.valid) begin
      next_unsup = 1'b1;  // RULE_06
    end
    sel.arch  = |(nvcfg3_q & MASK_ARCH);   // RULE_08
    sel.ploc  = |(nvcfg1_q & MASK_PLOC);   // RULE_09
    sel.usize = |(nvcfg3_q & MASK_USIZE);  // RULE_10
    next_map.index  = smd_index(sel);      // RULE_01
    next_map.valid  = next_map.index == IDX_BOT || next_map.index == IDX_TOP ||
                      next_map.index == IDX_UNI;  // RULE_05
    next_map.hybrid = !sel.arch;           // RULE_02
    next_map.ptop   = sel.ploc;            // RULE_03
    next_map.u256   = sel.usize;           // RULE_04
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvcfg1_q <= NVCFG1_RST;
      nvcfg3_q <= NVCFG3_RST;
      unsup_q  <= 1'b0;
      // map of the reset config, so release does not look like an undefined index
      map_q    <= '{index: IDX_BOT, valid: 1'b1, hybrid: 1'b1, ptop: 1'b0, u256: 1'b1};
    end else begin
      nvcfg1_q <= next_nvcfg1;
      nvcfg3_q <= next_nvcfg3;
      unsup_q  <= next_unsup;
      map_q    <= next_map;
    end
  end

  assign map_index    = map_q.index;
  assign map_valid    = map_q.valid;
  assign map_hybrid   = map_q.hybrid;
  assign param_top    = map_q.ptop;
  assign uniform_256k = map_q.u256;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic tbl_done;
  assign tbl_done = state_q == ST_DONE && psel && penable;

  AST_INDEX_ORDER: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_01
    ##1 map_index == {$past(nvcfg3_q[3]), $past(nvcfg1_q[2]), $past(nvcfg3_q[1])})
    else $error("map index not built from config bits in order");

  AST_HYBRID: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_02
    map_hybrid != map_index[2]) else $error("hybrid flag disagrees with index");

  AST_PTOP: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_03
    param_top == map_index[1]) else $error("parameter location disagrees with index");

  AST_U256: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_04
    uniform_256k == map_index[0]) else $error("sector size disagrees with index");

  AST_VALID: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_05
    map_valid == (map_index == 3'h1 || map_index == 3'h3 || map_index == 3'h5))
    else $error("valid flag wrong for index");

  AST_UNSUP: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_06
    !map_valid |=> unsup_q) else $error("unsupported index not flagged");

  AST_OPCODE: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_07
    tbl_done && (widx_q == 4'h0 || widx_q == 4'h2 || widx_q == 4'h4)
      |-> prdata[15:8] == 8'h65 && prdata[23:16] == 8'hff)
    else $error("detection command field wrong");

  AST_STEP1: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_08
    tbl_done && widx_q == 4'h0 |-> prdata[31:24] == 8'h08) else $error("step one mask wrong");

  AST_STEP2: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_09
    tbl_done && widx_q == 4'h3 |-> prdata == 32'h0000_0002) else $error("step two address wrong");

  AST_STEP3: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_10
    tbl_done && widx_q == 4'h4 |-> prdata[31:24] == 8'h02) else $error("step three mask wrong");

  AST_END_FLAG: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_11
    tbl_done && (widx_q == 4'h0 || widx_q == 4'h2 || widx_q == 4'h4)
      |-> prdata[1:0] == {1'b0, widx_q == 4'h4}) else $error("descriptor end flag wrong");

  AST_HEADER: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_12
    tbl_done && (widx_q == 4'h6 || widx_q == 4'ha)
      |-> prdata[23:16] == 8'h02 && prdata[1:0] == 2'h2) else $error("map header wrong");

  AST_SIZE: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_13
    tbl_done && widx_q == 4'h7 |-> prdata[31:8] == 24'h00007f) else $error("region size wrong");

  AST_ERASE1: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_14
    tbl_done && widx_q == 4'h7 |-> prdata[3:0] == 4'h1) else $error("small region erase types wrong");

  AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_15
    tbl_done && (widx_q < 4'h7 && !widx_q[0] || widx_q == 4'ha)
      |-> prdata[7:2] == 6'h3f) else $error("reserved bits not all ones");

  AST_ERASE3: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_16
    tbl_done && (widx_q == 4'h8 || widx_q == 4'h9) |-> prdata[3:0] == 4'h4)
    else $error("large region erase types wrong");

  AST_FETCH_TIME: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_17
    state_q == ST_IDLE && setup && !pwrite && kind == K_TBL
      |=> !pready [*5] ##1 pready) else $error("table read latency wrong");

endmodule : smd_top

`default_nettype wire

// [hw/smd_pkg.sv]
// Purpose: shared constants, carriers and table builders for the sector map discovery block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   table words are built from their fields so the encoding stays readable

package smd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_NVCFG1   = 12'h000;
  localparam logic [11:0] OFF_NVCFG3   = 12'h004;
  localparam logic [11:0] OFF_STATUS   = 12'h008;
  localparam logic [11:0] OFF_TBL_BASE = 12'h100;
  localparam logic [11:0] TBL_BYTES    = 12'h02c;
  localparam logic [3:0]  TBL_WORD_MAX = 4'ha;

  localparam logic [7:0]  NVCFG1_RST   = 8'h00;
  localparam logic [7:0]  NVCFG3_RST   = 8'h02;

  // status bit positions
  localparam int unsigned ST_IDX_LSB   = 0;
  localparam int unsigned ST_VALID     = 3;
  localparam int unsigned ST_HYBRID    = 4;
  localparam int unsigned ST_PTOP      = 5;
  localparam int unsigned ST_U256      = 6;
  localparam int unsigned ST_UNSUP     = 7;

  localparam logic [2:0]  FETCH_LAST   = 3'h4;

  // ----------------------------------------------------------------
  // discovery encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  OP_READ_ANY  = 8'h65;
  localparam logic [1:0]  ADDR_LEN_VAR = 2'h3;
  localparam logic [1:0]  RFU2         = 2'h3;
  localparam logic [3:0]  LAT_VAR      = 4'hf;
  localparam logic [5:0]  RFU6         = 6'h3f;
  localparam logic [3:0]  RFU4         = 4'hf;
  localparam logic [7:0]  RFU8         = 8'hff;
  localparam logic [7:0]  MASK_ARCH    = 8'h08;
  localparam logic [7:0]  MASK_PLOC    = 8'h04;
  localparam logic [7:0]  MASK_USIZE   = 8'h02;
  localparam logic [31:0] ADDR_NVCFG3  = 32'h0000_0004;
  localparam logic [31:0] ADDR_NVCFG1  = 32'h0000_0002;
  localparam logic [2:0]  IDX_BOT      = 3'h1;
  localparam logic [2:0]  IDX_TOP      = 3'h3;
  localparam logic [2:0]  IDX_UNI      = 3'h5;
  localparam logic [7:0]  REGION_CM1   = 8'h02;
  localparam logic [23:0] SIZE_SMALL   = 24'h00007f;
  localparam logic [23:0] SIZE_MID     = 24'h00037f;
  localparam logic [23:0] SIZE_REST    = 24'h03fbff;
  localparam logic [3:0]  ERASE_T1     = 4'h1;
  localparam logic [3:0]  ERASE_T3     = 4'h4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic arch;
    logic ploc;
    logic usize;
  } smd_sel_t;

  typedef struct packed {
    logic [2:0] index;
    logic       valid;
    logic       hybrid;
    logic       ptop;
    logic       u256;
  } smd_map_t;

  typedef enum logic [2:0] {K_CFG1, K_CFG3, K_STAT, K_TBL, K_NONE} smd_kind_t;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic smd_kind_t smd_decode(input logic [11:0] a);
    if (a == OFF_NVCFG1) return K_CFG1;
    if (a == OFF_NVCFG3) return K_CFG3;
    if (a == OFF_STATUS) return K_STAT;
    if (a >= OFF_TBL_BASE && a < OFF_TBL_BASE + TBL_BYTES && a[1:0] == 2'h0) return K_TBL;
    return K_NONE;
  endfunction : smd_decode

  function automatic logic [2:0] smd_index(input smd_sel_t s);
    return {s.arch, s.ploc, s.usize};
  endfunction : smd_index

  function automatic logic [63:0] smd_detect(input logic [7:0] mask, input logic [31:0] addr,
                                             input logic last);
    return {addr, mask, ADDR_LEN_VAR, RFU2, LAT_VAR, OP_READ_ANY, RFU6, 1'b0, last};  // RULE_07 RULE_11
  endfunction : smd_detect

  function automatic logic [31:0] smd_header(input logic [7:0] id);
    return {RFU8, REGION_CM1, id, RFU6, 1'b1, 1'b0};  // RULE_12 RULE_15
  endfunction : smd_header

  function automatic logic [31:0] smd_region(input logic [23:0] size, input logic [3:0] erase);
    return {size, RFU4, erase};  // RULE_13
  endfunction : smd_region

  function automatic logic [31:0] smd_table_word(input logic [3:0] idx);
    logic [63:0] d_arch;
    logic [63:0] d_ploc;
    logic [63:0] d_usize;
    d_arch  = smd_detect(MASK_ARCH, ADDR_NVCFG3, 1'b0);
    d_ploc  = smd_detect(MASK_PLOC, ADDR_NVCFG1, 1'b0);
    d_usize = smd_detect(MASK_USIZE, ADDR_NVCFG3, 1'b1);
    case (idx)
      4'h0:    return d_arch[31:0];
      4'h1:    return d_arch[63:32];
      4'h2:    return d_ploc[31:0];
      4'h3:    return d_ploc[63:32];
      4'h4:    return d_usize[31:0];
      4'h5:    return d_usize[63:32];
      4'h6:    return smd_header({5'h00, IDX_BOT});
      4'h7:    return smd_region(SIZE_SMALL, ERASE_T1);  // RULE_14
      4'h8:    return smd_region(SIZE_MID, ERASE_T3);    // RULE_16
      4'h9:    return smd_region(SIZE_REST, ERASE_T3);   // RULE_16
      4'ha:    return smd_header({5'h00, IDX_TOP});
      default: return 32'h0000_0000;
    endcase
  endfunction : smd_table_word

endpackage : smd_pkg

// [hw/smd_rom.sv]
// Purpose: byte-wide discovery table store
// Assumes: byte address is word index and lane, lane 0 least significant
// Notes:   one cycle from address to byte

`timescale 1ns/10ps
`default_nettype none

module smd_rom
  import smd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] byte_addr,
  output logic      [7:0] byte_data
);

  logic [31:0] word;
  logic [7:0]  next_byte_data;

  // ----------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------
  always_comb begin
    word           = smd_table_word(byte_addr[5:2]);
    next_byte_data = word[{byte_addr[1:0], 3'h0} +: 8];  // RULE_17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_data <= 8'h00;
    end else begin
      byte_data <= next_byte_data;
    end
  end

endmodule : smd_rom

`default_nettype wire

// [testbench/smd_host_model.sv]
// Purpose: host side model, apb master plus discovery walk over the table
// Assumes: flash register address 04h is config three, 02h is config one
// Notes:   waits for pready are open; only the bench watchdog ends a stall

`timescale 1ns/10ps
`default_nettype none

module smd_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
  end

  // ----------------------------------------------------------------
  // one apb transfer
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // values read here are those sampled at the edge, before flops update
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // ----------------------------------------------------------------
  // discovery walk, three detect descriptors of two words each
  // ----------------------------------------------------------------
  task automatic discover(output logic [2:0] idx);
    logic [31:0] desc;
    logic [31:0] fadr;
    logic [31:0] val;
    logic        e;
    idx = 3'h0;
    for (int k = 0; k < 3; k++) begin
      xfer(1'b0, 12'h100 + 12'(8 * k), 32'h0, 4'hf, desc, e);
      xfer(1'b0, 12'h104 + 12'(8 * k), 32'h0, 4'hf, fadr, e);
      xfer(1'b0, (fadr == 32'h4) ? 12'h004 : 12'h000, 32'h0, 4'hf, val, e);
      // msb first concatenation; only supported combinations are configured
      idx = {idx[1:0], |(val[7:0] & desc[31:24])};
    end
  endtask : discover
endmodule : smd_host_model

`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the sector map discovery block
// Assumes: 25 ns clock, reset held 12 cycles
// Notes:   expected table words are worked out from the field encodings

`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import smd_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [2:0]  map_index;
  logic        map_valid;
  logic        map_hybrid;
  logic        param_top;
  logic        uniform_256k;
  int          mismatches;
  int          checked;

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  smd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
               .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
               .pslverr(pslverr), .map_index(map_index), .map_valid(map_valid),
               .map_hybrid(map_hybrid), .param_top(param_top), .uniform_256k(uniform_256k));

  smd_host_model host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
                       .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b0, a, 32'h0, 4'hf, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic err);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, s, r, e);
    chk({31'h0, e}, {31'h0, err});
  endtask : wr

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic table_words();
    // detect: mask, len 11b, rfu 11b, latency 1111b, 65h, rfu 111111b, type 0, end flag
    logic [31:0] exp [11] = '{32'h08ff65fc, 32'h00000004, 32'h04ff65fc, 32'h00000002,
                              32'h02ff65fd, 32'h00000004, 32'hff0201fe, 32'h00007ff1,
                              32'h00037ff4, 32'h03fbfff4, 32'hff0203fe};
    for (int i = 0; i < 11; i++)
      rd(12'h100 + 12'(4 * i), exp[i], 1'b0);
  endtask : table_words

  task automatic map_select();
    logic [7:0] c3 [3]  = '{8'h02, 8'h02, 8'h0a};
    logic [7:0] c1 [3]  = '{8'h00, 8'h04, 8'h00};
    logic [7:0] st [3]  = '{8'h59, 8'h7b, 8'h4d};
    logic [2:0] ix [3]  = '{3'h1, 3'h3, 3'h5};
    logic [2:0] found;
    for (int i = 0; i < 3; i++) begin
      // config one first, so no step passes through an undefined index
      wr(12'h000, {24'h0, c1[i]}, 4'hf, 1'b0);
      wr(12'h004, {24'h0, c3[i]}, 4'hf, 1'b0);
      rd(12'h008, {24'h0, st[i]}, 1'b0);
      chk({25'h0, map_index, map_valid, map_hybrid, param_top, uniform_256k},
          {25'h0, st[i][2:0], st[i][3], st[i][4], st[i][5], st[i][6]});
      host.discover(found);
      chk({29'h0, found}, {29'h0, ix[i]});
    end
  endtask : map_select

  task automatic reset_and_refusals();
    rd(12'h000, 32'h0000_0000, 1'b0);
    rd(12'h004, 32'h0000_0002, 1'b0);
    rd(12'h008, 32'h0000_0059, 1'b0);
    rd(12'h00c, 32'h0000_0000, 1'b1);
    wr(12'h100, 32'h0, 4'hf, 1'b1);
    rd(12'h100, 32'h08ff65fc, 1'b0);
    wr(12'h000, 32'h0000_0004, 4'he, 1'b0);
    rd(12'h000, 32'h0000_0000, 1'b0);
    rd(12'h12c, 32'h0000_0000, 1'b1);
  endtask : reset_and_refusals

  task automatic undefined_index();
    // index 0 has no defined map; sticky flag survives a clear while still invalid
    wr(12'h004, 32'h0000_0000, 4'hf, 1'b0);
    // sticky flag sets one edge after map_valid falls
    @(posedge pclk);
    rd(12'h008, 32'h0000_0090, 1'b0);
    wr(12'h008, 32'h0000_0080, 4'hf, 1'b0);
    rd(12'h008, 32'h0000_0090, 1'b0);
    wr(12'h004, 32'h0000_0002, 4'hf, 1'b0);
    wr(12'h008, 32'h0000_0080, 4'hf, 1'b0);
    rd(12'h008, 32'h0000_0059, 1'b0);
  endtask : undefined_index

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    checked    = 0;
    presetn    = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_and_refusals();
    table_words();
    map_select();
    undefined_index();
    tally_and_finish();
  end

  initial begin
    #(25 * 6000);
    mismatches++;
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
